// ---- rtl/ccf_clock_ctrl.sv ----
/*
 * Clock fallback control, local clock output select and three programmable dividers.
 * Assumes all clock sources arrive as levels synchronous to CORE_CLK and that the
 * host register port is a one-cycle write/read strobe with a byte address.
 */
// Behaviour
// - type 00 falls back to oscillator/4
// - type 01 disables automatic fallback
// - type 10 falls A/B clocks to secondary
// - enabled failure flag switches to fallback selection
// - fallback held until software clear input
// - sticky system error bit marks automatic fallback entry
// - 8 MHz select low means MC-1 mode
// - force bit applies fallback immediately
// - three-bit fallback clock select decode
// - fallback oscillator/4 bypasses resource multiplexer
// - two registers, two nibble selects each
// - codes 0000-0111 pick local clock source
// - codes 1000-1111 give inverted sources
// - local clocks usable as bit clocks, netref
// - three dividers at consecutive registers
// - divider divides by value plus one
// - power-of-two and 193 give 50% duty
// - fallback resource select picks PLL one source
// - force applies resource, type, clock fields together
`timescale 1ns/1ns
module ccf_clock_ctrl
	import ccf_pkg::*;
(
	// Clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic      [7:0]  REG_RDATA,
	// Failure detection and system control
	input  wire logic [7:0]  CLK_FAIL_FLAGS,
	input  wire logic [7:0]  CLK_FAIL_ENABLE,
	input  wire logic        FALLBACK_CLEAR,
	input  wire logic        SYSTEM_ERROR_FLAGS_CLEAR,
	input  wire logic        BP8M_INPUT_SEL,
	input  wire logic        COMPAT_FALLBACK_DRIVE,
	input  wire logic [2:0]  PRIMARY_CLOCK_SELECT,
	input  wire logic [1:0]  PRIMARY_RESOURCE_SELECT,
	// Clock selection results
	output logic      [2:0]  EFF_CLOCK_SELECT,
	output logic      [1:0]  EFF_RESOURCE_SELECT,
	output logic             RESOURCE_MUX_BYPASS,
	output logic             AB_CLOCKS_DISABLE,
	output logic             COMPAT_CLK_EN,
	output logic             MC1_MODE,
	output logic             FALLBACK_ACTIVE,
	output logic             SYSTEM_ERROR_FLAGS_FALLBACK,
	// Local clock sources and outputs
	input  wire logic        LOCAL_FRAME,
	input  wire logic        NETREF_CLK,
	input  wire logic        PLL2_DIV2_CLK,
	input  wire logic [3:0]  RATE_CLKS,
	output logic      [3:0]  LOCAL_CLOCK_OUTPUTS,
	// Dividers: 0 main, 1 netref, 2 resource
	input  wire logic [2:0]  DIV_SRC_CLK,
	output logic      [2:0]  DIV_OUT
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]            fbsel;
		logic [1:0][7:0]       lcsel;
		logic [2:0][7:0]       div_cfg;
		logic [2:0][7:0]       div_act;
		logic [2:0][7:0]       div_cnt;
		logic [2:0]            div_in;
		logic [2:0]            div_out;
		logic [3:0][3:0]       lc_act;
		logic [3:0]            lc_out;
		ccf_fb_state_t         fb_st;
		logic                  err_fb;
		logic [7:0]            rdata;
	} ccf_state_t;

	ccf_state_t s_q;
	ccf_state_t s_d;

	logic [1:0] fallback_type_select;
	logic [2:0] fallback_clock_select;
	logic [1:0] fallback_resource_select;
	logic       force_fb;
	logic       fail;
	logic       auto_en;
	logic       fb_trig;
	logic       use_fb;
	logic [7:0] lc_src;

	logic [2:0][7:0] dv_act_d;
	logic [2:0][7:0] dv_cnt_d;
	logic [2:0]      dv_out_d;
	logic [3:0][3:0] lc_act_d;
	logic [3:0]      lc_out_d;

	assign fallback_type_select      = s_q.fbsel[FTS_LSB +: 2];
	assign fallback_clock_select    = s_q.fbsel[FCS_LSB +: 3];
	assign fallback_resource_select      = s_q.fbsel[FRS_LSB +: 2];
	assign force_fb = s_q.fbsel[FF_BIT];
	assign fail     = |(CLK_FAIL_FLAGS & CLK_FAIL_ENABLE);
	// Type 11 is undefined, so it is kept out of the automatic path
	assign auto_en  = (fallback_type_select == FTS_MAIN_TO_OSC4) || (fallback_type_select == FTS_AB_TO_SEC);
	assign fb_trig  = fail && auto_en;
	assign use_fb   = (s_q.fb_st == FB_ACTIVE) || force_fb;
	assign lc_src   = {RATE_CLKS, PLL2_DIV2_CLK, NETREF_CLK, LOCAL_FRAME, 1'b0};

	// ----------------------------------------
	// Dividers
	// ----------------------------------------
	for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
		logic rise;
		logic tc;
		logic pow2;
		assign rise = DIV_SRC_CLK[i] && !s_q.div_in[i];
		assign tc   = rise && (s_q.div_cnt[i] == s_q.div_act[i]);
		// New value only loads at terminal count so the running period is never cut short
		assign dv_act_d[i] = tc ? s_q.div_cfg[i] : s_q.div_act[i];
		assign dv_cnt_d[i] = tc ? 8'h00 : (rise ? 8'(s_q.div_cnt[i] + 8'h01) : s_q.div_cnt[i]);
		assign pow2 = ((9'(s_q.div_act[i]) + 9'h001) & {1'b0, s_q.div_act[i]}) == 9'h000;
		always_comb begin
			if (s_q.div_act[i] == 8'h00) begin
				dv_out_d[i] = DIV_SRC_CLK[i];
			end else if (pow2 || s_q.div_act[i] == DIV193_VALUE) begin
				dv_out_d[i] = dv_cnt_d[i] <= (s_q.div_act[i] >> 1);
			end else begin
				dv_out_d[i] = (dv_cnt_d[i] == 8'h00) && DIV_SRC_CLK[i];
			end
		end
	end

	// ----------------------------------------
	// Local clock outputs
	// ----------------------------------------
	for (genvar i = 0; i < NUM_LCLK; i++) begin : g_lclk
		logic [3:0] req;
		logic       req_lvl;
		assign req     = s_q.lcsel[i / 2][(i % 2) * 4 +: 4];
		assign req_lvl = lc_src[req[2:0]] ^ req[3];
		// Switching only while old and new sources agree avoids a runt edge
		// Two steady levels have no edge to wait for, so they swap at once
		assign lc_act_d[i] = ((req_lvl == s_q.lc_out[i]) ||
			(req[2:0] == 3'h0 && s_q.lc_act[i][2:0] == 3'h0)) ? req : s_q.lc_act[i];
		assign lc_out_d[i] = lc_src[lc_act_d[i][2:0]] ^ lc_act_d[i][3];
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d         = s_q;
		s_d.div_act = dv_act_d;
		s_d.div_cnt = dv_cnt_d;
		s_d.div_out = dv_out_d;
		s_d.div_in  = DIV_SRC_CLK;
		s_d.lc_act  = lc_act_d;
		s_d.lc_out  = lc_out_d;
		if (REG_WR) begin
			case (REG_ADDR)
				OFS_FALLBACK_SEL: s_d.fbsel      = REG_WDATA;
				OFS_LCSEL_UPPER:  s_d.lcsel[1]   = REG_WDATA;
				OFS_LCSEL_LOWER:  s_d.lcsel[0]   = REG_WDATA;
				OFS_MAIN_DIV:     s_d.div_cfg[0] = REG_WDATA;
				OFS_NETREF_DIV:   s_d.div_cfg[1] = REG_WDATA;
				OFS_RES_DIV:      s_d.div_cfg[2] = REG_WDATA;
				default:          s_d.fbsel      = s_q.fbsel;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				OFS_FALLBACK_SEL: s_d.rdata = s_q.fbsel;
				OFS_LCSEL_UPPER:  s_d.rdata = s_q.lcsel[1];
				OFS_LCSEL_LOWER:  s_d.rdata = s_q.lcsel[0];
				OFS_MAIN_DIV:     s_d.rdata = s_q.div_cfg[0];
				OFS_NETREF_DIV:   s_d.rdata = s_q.div_cfg[1];
				OFS_RES_DIV:      s_d.rdata = s_q.div_cfg[2];
				default:          s_d.rdata = 8'h00;
			endcase
		end
		case (s_q.fb_st)
			FB_PRIMARY: begin
				if (fb_trig) begin
					s_d.fb_st = FB_ACTIVE;
				end
			end
			FB_ACTIVE: begin
				// A failure still pending wins over the clear
				if (FALLBACK_CLEAR && !fb_trig) begin
					s_d.fb_st = FB_PRIMARY;
				end
			end
			default: s_d.fb_st = FB_PRIMARY;
		endcase
		if (SYSTEM_ERROR_FLAGS_CLEAR) begin
			s_d.err_fb = 1'b0;
		end
		if (s_d.fb_st == FB_ACTIVE && s_q.fb_st == FB_PRIMARY) begin
			s_d.err_fb = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_q         <= '0;
			s_q.fbsel   <= RST_FALLBACK_SEL;
			s_q.lcsel   <= {2{RST_LCSEL}};
			s_q.div_cfg <= {3{RST_DIV}};
			s_q.div_act <= {3{RST_DIV}};
			s_q.fb_st   <= FB_PRIMARY;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always_comb begin
		EFF_CLOCK_SELECT    = PRIMARY_CLOCK_SELECT;
		EFF_RESOURCE_SELECT = PRIMARY_RESOURCE_SELECT;
		RESOURCE_MUX_BYPASS = 1'b0;
		if (use_fb) begin
			if (fallback_type_select == FTS_MAIN_TO_OSC4) begin
				EFF_CLOCK_SELECT = FCS_OSC_DIV4;
			end else begin
				EFF_CLOCK_SELECT = fallback_clock_select;
			end
			EFF_RESOURCE_SELECT = fallback_resource_select;
			// Oscillator/4 is taken straight off the oscillator, not via the resource mux
			RESOURCE_MUX_BYPASS = EFF_CLOCK_SELECT == FCS_OSC_DIV4;
		end
	end

	assign AB_CLOCKS_DISABLE   = use_fb && (fallback_type_select == FTS_AB_TO_SEC);
	assign COMPAT_CLK_EN       = use_fb ? COMPAT_FALLBACK_DRIVE : 1'b1;
	assign MC1_MODE            = !BP8M_INPUT_SEL;
	assign FALLBACK_ACTIVE     = use_fb;
	assign SYSTEM_ERROR_FLAGS_FALLBACK     = s_q.err_fb;
	assign REG_RDATA           = s_q.rdata;
	assign LOCAL_CLOCK_OUTPUTS = s_q.lc_out;
	assign DIV_OUT             = s_q.div_out;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	chk_auto_entry: assert property (fail && auto_en && s_q.fb_st == FB_PRIMARY |=> FALLBACK_ACTIVE)
		else $error("enabled failure did not enter fallback");
	chk_type01_off: assert property (fallback_type_select == FTS_DISABLED && !force_fb && s_q.fb_st == FB_PRIMARY |=>
		s_q.fb_st == FB_PRIMARY) else $error("fallback entered with type 01");
	chk_osc4_sel: assert property (use_fb && fallback_type_select == FTS_MAIN_TO_OSC4 |->
		EFF_CLOCK_SELECT == FCS_OSC_DIV4 && RESOURCE_MUX_BYPASS) else $error("type 00 not oscillator/4");
	chk_hold_fb: assert property (s_q.fb_st == FB_ACTIVE && !FALLBACK_CLEAR |=> s_q.fb_st == FB_ACTIVE)
		else $error("fallback dropped without clear");
	chk_err_set: assert property ($rose(s_q.fb_st == FB_ACTIVE) |-> SYSTEM_ERROR_FLAGS_FALLBACK)
		else $error("fallback error bit not set");
	chk_force_fields: assert property (force_fb && fallback_type_select != FTS_MAIN_TO_OSC4 |->
		EFF_CLOCK_SELECT == fallback_clock_select && EFF_RESOURCE_SELECT == fallback_resource_select) else $error("force did not apply fields");
	chk_div_period: assert property ($rose(DIV_SRC_CLK[0]) && s_q.div_cnt[0] == s_q.div_act[0] |=>
		s_q.div_cnt[0] == 8'h00 && s_q.div_act[0] == $past(s_q.div_cfg[0])) else $error("divider wrap wrong");
	chk_div_bypass: assert property (s_q.div_act[1] == 8'h00 |=> DIV_OUT[1] == $past(DIV_SRC_CLK[1]))
		else $error("bypass divider does not follow input");
	chk_lc_invert: assert property (s_q.lc_act[0] == 4'h8 ##1 s_q.lc_act[0] == 4'h8 |->
		LOCAL_CLOCK_OUTPUTS[0]) else $error("code 1000 not high");
	chk_lc_noglitch: assert property (s_q.lc_act[2] != $past(s_q.lc_act[2]) &&
		(s_q.lc_act[2][2:0] != 3'h0 || $past(s_q.lc_act[2][2:0]) != 3'h0) |->
		$stable(LOCAL_CLOCK_OUTPUTS[2])) else $error("runt edge on select change");
	chk_lc_static: assert property (s_q.lc_act[1][2:0] == 3'h0 && s_q.lcsel[0][6:4] == 3'h0 |=>
		s_q.lc_act[1] == $past(s_q.lcsel[0][7:4])) else $error("steady level swap stalled");
	chk_err_setwins: assert property (fb_trig && SYSTEM_ERROR_FLAGS_CLEAR && s_q.fb_st == FB_PRIMARY |=>
		SYSTEM_ERROR_FLAGS_FALLBACK) else $error("error clear beat a new fallback");
	chk_primary_pass: assert property (!use_fb |-> EFF_CLOCK_SELECT == PRIMARY_CLOCK_SELECT &&
		EFF_RESOURCE_SELECT == PRIMARY_RESOURCE_SELECT && !AB_CLOCKS_DISABLE && COMPAT_CLK_EN)
		else $error("primary selection not passed through");
	chk_ab_off: assert property (use_fb && fallback_type_select == FTS_AB_TO_SEC |-> AB_CLOCKS_DISABLE &&
		COMPAT_CLK_EN == COMPAT_FALLBACK_DRIVE) else $error("A/B clocks left on in fallback");
	chk_type11_off: assert property (&fallback_type_select && !force_fb && s_q.fb_st == FB_PRIMARY |=>
		s_q.fb_st == FB_PRIMARY) else $error("fallback entered with type 11");
	chk_div_count: assert property (s_q.div_cnt[2] <= s_q.div_act[2])
		else $error("resource divider count past its value");
	chk_div_load: assert property (s_q.div_act[1] != $past(s_q.div_act[1]) |->
		s_q.div_cnt[1] == 8'h00)
		else $error("divider value changed mid period");

	// Main scenarios the bench is expected to reach
	cov_auto_fb:  cover property (s_q.fb_st == FB_PRIMARY ##1 s_q.fb_st == FB_ACTIVE);
	cov_clear_fb: cover property (s_q.fb_st == FB_ACTIVE ##1 s_q.fb_st == FB_PRIMARY);
	cov_div193:   cover property (s_q.div_act[2] == DIV193_VALUE && s_q.div_cnt[2] == DIV193_VALUE);
	cov_lc_swap:  cover property (s_q.lc_act[1] != $past(s_q.lc_act[1]));
	cov_force:    cover property (force_fb && s_q.fb_st == FB_PRIMARY);
endmodule

// ---- rtl/ccf_pkg.sv ----
/*
 * Package for the clock fallback and local clock select block: register offsets,
 * field positions, reset values and encodings.
 * Assumes byte-wide registers behind a simple synchronous register port.
 */
package ccf_pkg;
	// ----------------------------------------
	// Register offsets and block counts
	// ----------------------------------------
	localparam logic [7:0] OFS_FALLBACK_SEL = 8'h04;
	localparam logic [7:0] OFS_LCSEL_UPPER  = 8'h05;
	localparam logic [7:0] OFS_LCSEL_LOWER  = 8'h06;
	localparam logic [7:0] OFS_MAIN_DIV     = 8'h07;
	localparam logic [7:0] OFS_NETREF_DIV   = 8'h08;
	localparam logic [7:0] OFS_RES_DIV      = 8'h09;
	localparam int         NUM_DIV          = 3;
	localparam int         NUM_LCLK         = 4;

	// ----------------------------------------
	// Fallback selection fields
	// ----------------------------------------
	localparam int FRS_LSB  = 6;
	localparam int FTS_LSB  = 4;
	localparam int FF_BIT   = 3;
	localparam int FCS_LSB  = 0;

	localparam logic [1:0] FTS_MAIN_TO_OSC4 = 2'h0;
	localparam logic [1:0] FTS_DISABLED     = 2'h1;
	localparam logic [1:0] FTS_AB_TO_SEC    = 2'h2;

	localparam logic [2:0] FCS_OSC_DIV4 = 3'h0;
	localparam logic [2:0] FCS_OSC      = 3'h1;
	localparam logic [2:0] FCS_A_CLOCKS = 3'h2;
	localparam logic [2:0] FCS_B_CLOCKS = 3'h3;
	localparam logic [2:0] FCS_NETREF   = 3'h4;

	localparam logic [1:0] RES_EXT_4M   = 2'h0;
	localparam logic [1:0] RES_DIVIDER  = 2'h1;
	localparam logic [1:0] RES_DPLL_2M  = 2'h2;
	localparam logic [1:0] RES_DPLL_4M  = 2'h3;

	// ----------------------------------------
	// Reset values and the divide-by-193 setting
	// ----------------------------------------
	localparam logic [7:0] RST_FALLBACK_SEL = 8'h00;
	localparam logic [7:0] RST_LCSEL        = 8'h00;
	localparam logic [7:0] RST_DIV          = 8'h00;
	localparam logic [7:0] DIV193_VALUE     = 8'hc0;

	typedef enum logic {
		FB_PRIMARY,
		FB_ACTIVE
	} ccf_fb_state_t;
endpackage

// ---- test/ccf_src_model.sv ----
/*
 * Source model for the clock block: local clock sources and divider inputs.
 * Assumes the block samples on the rising CORE_CLK edge; sources step just after it.
 */
`timescale 1ns/1ns
module ccf_src_model (
	// Clock
	input  wire logic       CORE_CLK,
	// Sources
	output logic            LOCAL_FRAME,
	output logic            NETREF_CLK,
	output logic            PLL2_DIV2_CLK,
	output logic      [3:0] RATE_CLKS,
	output logic      [2:0] DIV_SRC_CLK
);
	logic [7:0] cnt_q = 8'h00;

	always @(posedge CORE_CLK) cnt_q <= cnt_q + 8'h01;

	// Rates scaled to the core clock; only their order matters to the block
	assign RATE_CLKS     = {cnt_q[0], cnt_q[1], cnt_q[2], cnt_q[3]};
	assign NETREF_CLK    = cnt_q[4];
	assign PLL2_DIV2_CLK = cnt_q[5];
	assign LOCAL_FRAME   = &cnt_q[4:0];
	assign DIV_SRC_CLK   = {3{cnt_q[1]}};
endmodule

// ---- test/ccf_clock_ctrl_tb.sv ----
/*
 * Bench for the clock block: registers, fallback, local clocks, dividers.
 * Assumes the source model above; divider inputs rise every 4 core cycles.
 */
`timescale 1ns/1ns
module ccf_clock_ctrl_tb;
	import ccf_pkg::*;
	logic        clk = 0, rst = 1, wr = 0, rd = 0, fclr = 0, eclr = 0, bp8 = 1, cdrv = 0;
	logic [7:0]  addr = 0, wdat = 0, rdat, flags = 0, fen = 8'hff, r;
	logic [2:0]  pcs = 3'h5, ecs, dsrc, dout;
	logic [1:0]  prs = 2'h1, ers;
	logic        byp, abd, cen, mc1, fba, serr, lfr, nref, pll2;
	logic [3:0]  rate, lco, e;
	logic [15:0] sel, hi, lo, n;
	int          n_fail = 0, num_checks = 0;
	// {flag, fallback selection, {active, clock sel, resource sel, bypass, ab off}}
	logic [16:0] rows [4] = '{{1'b1, 8'h83, 8'h8a}, {1'b1, 8'h93, 8'h54},
		{1'b1, 8'ha5, 8'hd9}, {1'b0, 8'hdc, 8'hcc}};
	logic [7:0]  dv [6] = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h05, 8'hc0};

	always #10 clk = ~clk;

	ccf_clock_ctrl uut (.CORE_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wdat),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .CLK_FAIL_FLAGS(flags), .CLK_FAIL_ENABLE(fen),
		.FALLBACK_CLEAR(fclr), .SYSTEM_ERROR_FLAGS_CLEAR(eclr), .BP8M_INPUT_SEL(bp8), .COMPAT_FALLBACK_DRIVE(cdrv),
		.PRIMARY_CLOCK_SELECT(pcs), .PRIMARY_RESOURCE_SELECT(prs), .EFF_CLOCK_SELECT(ecs),
		.EFF_RESOURCE_SELECT(ers), .RESOURCE_MUX_BYPASS(byp), .AB_CLOCKS_DISABLE(abd),
		.COMPAT_CLK_EN(cen), .MC1_MODE(mc1), .FALLBACK_ACTIVE(fba), .SYSTEM_ERROR_FLAGS_FALLBACK(serr),
		.LOCAL_FRAME(lfr), .NETREF_CLK(nref), .PLL2_DIV2_CLK(pll2), .RATE_CLKS(rate),
		.LOCAL_CLOCK_OUTPUTS(lco), .DIV_SRC_CLK(dsrc), .DIV_OUT(dout));
	ccf_src_model src (.CORE_CLK(clk), .LOCAL_FRAME(lfr), .NETREF_CLK(nref),
		.PLL2_DIV2_CLK(pll2), .RATE_CLKS(rate), .DIV_SRC_CLK(dsrc));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wreg(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdat = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rreg(logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		d = rdat;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		@(negedge clk);
		s = 0;
		@(negedge clk);
	endtask
	function automatic logic srcv(logic [3:0] c);
		logic [7:0] s;
		s = {rate, pll2, nref, lfr, 1'b0};
		return s[c[2:0]] ^ c[3];
	endfunction
	// Bounded wait while a divider output keeps its level, counting cycles
	task automatic hold(int i, logic lv, output logic [15:0] k);
		k = 0;
		while (dout[i] === lv && k < 16'd2000) begin
			@(negedge clk);
			k++;
		end
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		close_out();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (10) @(negedge clk);
		chk("rst outs", {fba, serr, lco, dout}, 16'h0);
		rst = 0;
		for (int a = 4; a <= 9; a++) begin
			rreg(8'(a), r);
			chk("rst reg", r, 8'h00);
		end
		for (int a = 4; a <= 10; a++) begin
			wreg(8'(a), 8'(a * 8'h1d));
			rreg(8'(a), r);
			chk("reg rw", r, (a <= 9) ? 8'(a * 8'h1d) : 8'h00);
		end
		$display("registers done");
		for (int i = 0; i < 4; i++) begin
			wreg(OFS_FALLBACK_SEL, rows[i][15:8]);
			flags = {7'h0, rows[i][16]};
			repeat (2) @(negedge clk);
			chk("fallback", {fba, ecs, ers, byp, abd}, rows[i][7:0]);
			chk("compat", cen, !rows[i][7]);
			if (rows[i][16]) chk("system_error_flags", serr, rows[i][7]);
			flags = 0;
			wreg(OFS_FALLBACK_SEL, 8'h00);
			fclr = 1;
			pulse(eclr);
			fclr = 0;
			chk("cleared", {fba, serr}, 16'h0);
		end
		$display("fallback table done");
		wreg(OFS_FALLBACK_SEL, 8'ha2);
		fen = 8'hfb;
		flags = 8'h04;
		repeat (3) @(negedge clk);
		chk("masked", fba, 0);
		fen = 8'hff;
		@(negedge clk);
		flags = 0;
		repeat (5) @(negedge clk);
		chk("held", fba, 1);
		flags = 8'h10;
		pulse(fclr);
		flags = 0;
		chk("clear refused", fba, 1);
		pulse(fclr);
		chk("clear", {fba, serr}, 16'h1);
		pulse(eclr);
		chk("err clear", serr, 0);
		flags = 8'h01;
		eclr = 1;
		@(negedge clk);
		eclr = 0;
		flags = 0;
		chk("set wins", serr, 1);
		pulse(fclr);
		pulse(eclr);
		bp8 = 0;
		@(negedge clk);
		chk("mc1", mc1, 1);
		bp8 = 1;
		@(negedge clk);
		chk("mc1 off", mc1, 0);
		$display("fallback hand tests done");
		for (int k = 0; k < 16; k++) begin
			sel = {k[3:0] ^ 4'h7, ~k[3:0], k[3:0] ^ 4'h8, k[3:0]};
			wreg(OFS_LCSEL_UPPER, sel[15:8]);
			wreg(OFS_LCSEL_LOWER, sel[7:0]);
			repeat (40) @(negedge clk);
			for (int j = 0; j < 6; j++) begin
				for (int c = 0; c < 4; c++) e[c] = srcv(sel[c * 4 +: 4]);
				@(negedge clk);
				chk("local clk", lco, e);
			end
		end
		wreg(OFS_LCSEL_LOWER, 8'h00);
		repeat (4) @(negedge clk);
		wreg(OFS_LCSEL_LOWER, 8'h88);
		repeat (2) @(negedge clk);
		chk("static swap", lco[1:0], 2'b11);
		$display("local clocks done");
		foreach (dv[v]) begin
			wreg(OFS_MAIN_DIV, dv[v]);
			wreg(OFS_NETREF_DIV, dv[v]);
			wreg(OFS_RES_DIV, dv[v]);
			for (int i = 0; i < 3; i++) begin
				repeat (2) begin
					hold(i, 1, n);
					hold(i, 0, n);
				end
				hold(i, 1, hi);
				hold(i, 0, lo);
				chk("div period", hi + lo, (dv[v] + 16'd1) * 4);
				chk("div high", hi, (dv[v] != 0 && ((((dv[v] + 16'd1) & dv[v]) == 0) ||
					dv[v] == DIV193_VALUE)) ? (dv[v] / 2 + 16'd1) * 4 : 16'd2);
			end
		end
		$display("dividers done");
		wreg(OFS_FALLBACK_SEL, 8'h08);
		@(negedge clk);
		chk("forced", fba, 1);
		rst = 1;
		@(negedge clk);
		chk("mid rst", {fba, serr, lco, dout}, 16'h0);
		rst = 0;
		rreg(OFS_FALLBACK_SEL, r);
		chk("mid rst reg", r, 8'h00);
		rreg(OFS_RES_DIV, r);
		chk("mid rst div", r, 8'h00);
		$display("mid-run reset done");
		close_out();
	end
endmodule
